// ==== smpa_core.sv ====
module smpa_core
  import smpa_pkg::*;
#(
  parameter int DEPTH = 8192
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic pause_n,
  input wire logic protect_n,
  output logic sdo,
  output logic sdo_oe_n,
  output logic [7:0] protection_status
);
  import smpa_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [4:0] pins_s;
  logic sel_n_s, sclk_s, sdi_s, pause_n_s, protect_n_s;

  smpa_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({sel_n, sclk, sdi, pause_n, protect_n}),
    .sync_out(pins_s)
  );

  assign {sel_n_s, sclk_s, sdi_s, pause_n_s, protect_n_s} = pins_s;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] mem [DEPTH];
  logic sel_n_d, sclk_d;
  logic paused;
  logic write_latch_flag;
  logic protect_pin_gate;
  logic block_guard_high, block_guard_low;
  logic [7:0] shift_in;
  logic [2:0] bit_cnt;
  logic [7:0] opcode;
  logic [ADDR_W-1:0] addr;
  logic [7:0] tx_byte;
  logic wr_stopped;
  logic latch_drop;
  smpa_phase_e phase;

  // ---------------------------------------------------------------
  // Edge and pause decode
  // ---------------------------------------------------------------
  wire sel_fall = sel_n_d & ~sel_n_s;
  wire sel_rise = ~sel_n_d & sel_n_s;
  // Pause is only allowed to change with the clock low, so the
  // qualifier below is what the device sees as the freeze request
  wire pause_enter = ~pause_n_s & ~sclk_s & ~paused;
  wire pause_leave = pause_n_s & ~sclk_s & paused;
  wire active = ~sel_n_s & ~sel_n_d & ~paused;
  // Mode 3 idles high; a rise only counts after the clock has toggled
  wire sck_rise = active & ~sclk_d & sclk_s;
  wire sck_fall = active & sclk_d & ~sclk_s;
  wire [7:0] byte_in = {shift_in[6:0], sdi_s};
  wire byte_done = sck_rise & (bit_cnt == BIT_LAST);

  // ---------------------------------------------------------------
  // Protection decode
  // ---------------------------------------------------------------
  wire [1:0] guard = {block_guard_high, block_guard_low};
  wire addr_guarded =
    (guard == 2'b01) ? (addr >= GUARD_QUARTER_BASE) :
    (guard == 2'b10) ? (addr >= GUARD_HALF_BASE) :
    (guard == 2'b11) ? (addr >= GUARD_ALL_BASE) : 1'b0;
  // Protect pin deliberately absent from the array term
  wire array_wr_ok = write_latch_flag & ~addr_guarded & ~wr_stopped;
  wire status_wr_ok = write_latch_flag & ~(protect_pin_gate & ~protect_n_s);
  wire [7:0] status_word;
  assign status_word = {protect_pin_gate, 3'b000, block_guard_high, block_guard_low,
                        write_latch_flag, 1'b0};
  wire [ADDR_W-1:0] addr_inc = (addr == ADDR_LAST) ? '0 : addr + 1'b1;
  wire cmd_known = (byte_in == ENABLE_WRITES_CMD) | (byte_in == DISABLE_WRITES_CMD) |
                   (byte_in == STATUS_READ_CMD) | (byte_in == STATUS_WRITE_CMD) |
                   (byte_in == MEM_READ_CMD) | (byte_in == MEM_WRITE_CMD);
  wire mem_read_frame = (opcode == MEM_READ_CMD);
  wire mem_write_frame = (opcode == MEM_WRITE_CMD);
  wire load_tx = byte_done & ((phase == PH_ADDR_LO & mem_read_frame) |
                              (phase == PH_DATA & mem_read_frame));
  wire [ADDR_W-1:0] rd_addr = (phase == PH_ADDR_LO) ? {addr[ADDR_W-1:8], byte_in} : addr_inc;
  wire commit = byte_done & (phase == PH_DATA) & mem_write_frame & array_wr_ok;

  // Edge history and pause latch
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_n_d <= 1'b1;
      sclk_d <= 1'b0;
      paused <= 1'b0;
    end else begin
      sel_n_d <= sel_n_s;
      sclk_d <= sclk_s;
      if (pause_enter) paused <= 1'b1;
      else if (pause_leave) paused <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Receive shifter and phase machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
      opcode <= 8'h00;
      phase <= PH_OPCODE;
    end else if (sel_fall) begin
      bit_cnt <= 3'h0;
      phase <= PH_OPCODE;
      opcode <= 8'h00;
    end else if (sck_rise) begin
      shift_in <= byte_in;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        case (phase)
          PH_OPCODE: begin
            opcode <= byte_in;
            if (!cmd_known) phase <= PH_IGNORE;
            else if (byte_in == STATUS_READ_CMD || byte_in == STATUS_WRITE_CMD) phase <= PH_STATUS;
            else if (byte_in == MEM_READ_CMD || byte_in == MEM_WRITE_CMD) phase <= PH_ADDR_HI;
            else phase <= PH_IGNORE;
          end
          PH_ADDR_HI: phase <= PH_ADDR_LO;
          PH_ADDR_LO: phase <= PH_DATA;
          PH_DATA: phase <= PH_DATA;
          PH_STATUS: phase <= PH_IGNORE;
          PH_IGNORE: phase <= PH_IGNORE;
          default: phase <= PH_IGNORE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Address counter and array
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      addr <= '0;
      wr_stopped <= 1'b0;
    end else if (sel_fall) begin
      wr_stopped <= 1'b0;
    end else if (byte_done) begin
      if (phase == PH_ADDR_HI) addr[ADDR_W-1:8] <= byte_in[ADDR_W-9:0];
      else if (phase == PH_ADDR_LO) addr[7:0] <= byte_in;
      else if (phase == PH_DATA && mem_read_frame) addr <= addr_inc;
      else if (phase == PH_DATA && mem_write_frame) begin
        // Once stopped the address freezes for the rest of the burst
        if (array_wr_ok) addr <= addr_inc;
        else wr_stopped <= 1'b1;
      end
    end
  end

  // Array write; bytes land only at the eighth bit, so select rise
  // mid-byte leaves the array untouched
  always_ff @(posedge clk) begin
    if (commit) mem[addr] <= byte_in;
  end

  // ---------------------------------------------------------------
  // Status register and write latch
  // ---------------------------------------------------------------
  // Guard bits model nonvolatile cells: no reset term on purpose
  always_ff @(posedge clk) begin
    if (byte_done && phase == PH_STATUS && opcode == STATUS_WRITE_CMD && status_wr_ok) begin
      block_guard_high <= byte_in[BLOCK_GUARD_HIGH_BIT];
      block_guard_low <= byte_in[BLOCK_GUARD_LOW_BIT];
      protect_pin_gate <= byte_in[PROTECT_PIN_GATE_BIT];
    end
  end

  // Latch: set by the enable command at once, cleared at select rise after a disable, status write or memory write
  always_ff @(posedge clk) begin
    if (rst) begin
      write_latch_flag <= 1'b0;
      latch_drop <= 1'b0;
    end else if (sel_rise) begin
      if (latch_drop) write_latch_flag <= 1'b0;
      latch_drop <= 1'b0;
    end else if (byte_done && phase == PH_OPCODE) begin
      if (byte_in == ENABLE_WRITES_CMD) write_latch_flag <= 1'b1;
      latch_drop <= (byte_in == DISABLE_WRITES_CMD) | (byte_in == STATUS_WRITE_CMD) |
                    (byte_in == MEM_WRITE_CMD);
    end
  end

  // ---------------------------------------------------------------
  // Transmit path
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_byte <= 8'h00;
    end else if (byte_done && phase == PH_OPCODE && byte_in == STATUS_READ_CMD) begin
      tx_byte <= status_word;
    end else if (load_tx) begin
      tx_byte <= mem[rd_addr];
    end else if (sck_fall && bit_cnt != 3'h0) begin
      tx_byte <= {tx_byte[6:0], 1'b0};
    end
  end

  // Output drives only while a status or read byte is in flight;
  // a pause keeps the level frozen rather than floating
  wire talking = (phase == PH_STATUS && opcode == STATUS_READ_CMD) |
                 (phase == PH_DATA && mem_read_frame);
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
      protection_status <= STATUS_RESET;
    end else begin
      protection_status <= status_word;
      if (sel_n_s) begin
        sdo_oe_n <= 1'b1;
      end else if (sck_fall && talking) begin
        // First fall of a byte shows the loaded MSB; later falls show
        // the bit that the same edge shifts up, so no bit repeats
        sdo <= (bit_cnt == 3'h0) ? tx_byte[7] : tx_byte[6];
        sdo_oe_n <= 1'b0;
      end else if (sck_fall) begin
        sdo_oe_n <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
    protection_status[6:4] == 3'b000 && !protection_status[0]) else $error("reserved bit set");
  AST_LATCH_RESET: assert property (@(posedge clk)
    rst |=> !write_latch_flag) else $error("latch not clear");
  AST_LATCH_DROP: assert property (@(posedge clk) disable iff (rst)
    sel_rise && latch_drop |=> !write_latch_flag) else $error("latch kept");
  AST_NO_WR_UNLATCHED: assert property (@(posedge clk) disable iff (rst)
    commit |-> write_latch_flag && !addr_guarded) else $error("bad write");
  AST_WRAP: assert property (@(posedge clk) disable iff (rst)
    byte_done && phase == PH_DATA && mem_read_frame && addr == ADDR_LAST |=> addr == '0)
    else $error("no wrap");
  AST_STOP: assert property (@(posedge clk) disable iff (rst)
    wr_stopped && !sel_fall |=> $stable(addr)) else $error("address moved");
  AST_FLOAT: assert property (@(posedge clk) disable iff (rst)
    sel_n_s |=> sdo_oe_n) else $error("output driven");
  sequence s_paused;
    paused ##1 paused;
  endsequence
  AST_PAUSE: assert property (@(posedge clk) disable iff (rst)
    s_paused |-> $stable(bit_cnt)) else $error("moved in pause");
  AST_IGNORE: assert property (@(posedge clk) disable iff (rst)
    phase == PH_IGNORE && !sel_fall |=> phase == PH_IGNORE) else $error("left ignore");
  // Output may only move on a serial clock fall
  AST_SDO_ON_FALL: assert property (@(posedge clk) disable iff (rst)
    $changed(sdo) |-> $past(sck_fall)) else $error("sdo moved off edge");
  // Enable command sets the latch on its eighth bit
  AST_LATCH_SET: assert property (@(posedge clk) disable iff (rst)
    byte_done && phase == PH_OPCODE && byte_in == ENABLE_WRITES_CMD |=> write_latch_flag)
    else $error("latch not set");
  // Gate set and pin low: the status byte must not land
  sequence s_pin_blocked_write;
    byte_done && phase == PH_STATUS && opcode == STATUS_WRITE_CMD && protect_pin_gate && !protect_n_s;
  endsequence
  AST_PIN_BLOCK: assert property (@(posedge clk) disable iff (rst)
    s_pin_blocked_write |=> $stable(protect_pin_gate) && $stable(block_guard_high) && $stable(block_guard_low))
    else $error("status written through pin");
  // Input data during a read never reaches the array
  AST_READ_NO_COMMIT: assert property (@(posedge clk) disable iff (rst)
    mem_read_frame |-> !commit) else $error("write during read");
endmodule

// ==== smpa_master_model.sv ====
module smpa_master_model (
  input wire logic clk,
  output logic sel_n,
  output logic sclk,
  output logic sdi,
  output logic pause_n,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Mode 0 master, 64 ns serial clock
  // ------------------------------------------------------------
  logic drove;
  // Idle bus: deselected, clock parked low
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    pause_n = 1'b1;
    drove = 1'b0;
  end
  // Moves always land just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // New opcode only after a select fall
  task automatic frame_begin();
    tick(1);
    sel_n = 1'b0;
    drove = 1'b0;
    tick(4);
  endtask
  // Data set while clock low, sampled by slave on rise; pause only with clock low
  task automatic xfer(input logic [7:0] tx, input bit pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = tx[i];
      tick(4);
      if (pz && i == 4) begin
        pause_n = 1'b0;
        tick(4);
        sclk = 1'b1;
        tick(4);
        sclk = 1'b0;
        tick(4);
        pause_n = 1'b1;
        tick(4);
      end
      sclk = 1'b1;
      tick(4);
      rx[i] = sdo;
      if (sdo_oe_n === 1'b0) drove = 1'b1;
    end
  endtask
  // Released input shows the inverse, not a stale copy
  task automatic frame_end();
    sclk = 1'b0;
    tick(4);
    sel_n = 1'b1;
    sdi = ~sdi;
    tick(6);
  endtask
endmodule

// ==== smpa_pkg.sv ====
package smpa_pkg;
  // ---------------------------------------------------------------
  // Commands
  // ---------------------------------------------------------------
  localparam logic [7:0] ENABLE_WRITES_CMD = 8'h06;
  localparam logic [7:0] DISABLE_WRITES_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] MEM_READ_CMD = 8'h03;
  localparam logic [7:0] MEM_WRITE_CMD = 8'h02;
  // ---------------------------------------------------------------
  // Status register layout
  // ---------------------------------------------------------------
  localparam int WRITE_LATCH_FLAG_BIT = 1;
  localparam int BLOCK_GUARD_LOW_BIT = 2;
  localparam int BLOCK_GUARD_HIGH_BIT = 3;
  localparam int PROTECT_PIN_GATE_BIT = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Array geometry and protect ranges
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_LAST = 13'h1fff;
  localparam logic [12:0] GUARD_QUARTER_BASE = 13'h1800;
  localparam logic [12:0] GUARD_HALF_BASE = 13'h1000;
  localparam logic [12:0] GUARD_ALL_BASE = 13'h0000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ---------------------------------------------------------------
  // Frame phases
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    PH_OPCODE = 6'b00_0001,
    PH_ADDR_HI = 6'b00_0010,
    PH_ADDR_LO = 6'b00_0100,
    PH_DATA = 6'b00_1000,
    PH_STATUS = 6'b01_0000,
    PH_IGNORE = 6'b10_0000
  } smpa_phase_e;
endpackage

// ==== smpa_sync.sv ====
module smpa_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // Two-stage synchroniser; meta is read only by sync_out
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ==== spi_serial_memory_protect_access_tb.sv ====
`define SMPA_CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spi_serial_memory_protect_access_tb;
  import smpa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  logic clk, rst, sel_n, sclk, sdi, pause_n, protect_n, sdo, sdo_oe_n;
  logic [7:0] protection_status, s, r0, r1;
  int num_errors = 0;
  int n_tests = 0;
  smpa_core smpa_core_i (.clk(clk), .rst(rst), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .pause_n(pause_n),
    .protect_n(protect_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .protection_status(protection_status));
  smpa_master_model smpa_master_model_i (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
    .pause_n(pause_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Frame helpers
  // ------------------------------------------------------------
  task automatic cmd(input logic [7:0] op);
    smpa_master_model_i.frame_begin();
    smpa_master_model_i.xfer(op, 1'b0, r0);
    smpa_master_model_i.frame_end();
  endtask
  task automatic st_op(input logic [7:0] op, input logic [7:0] d);
    smpa_master_model_i.frame_begin();
    smpa_master_model_i.xfer(op, 1'b0, r0);
    smpa_master_model_i.xfer(d, 1'b0, s);
    smpa_master_model_i.frame_end();
  endtask
  task automatic mem(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
    input bit pz);
    smpa_master_model_i.frame_begin();
    smpa_master_model_i.xfer(op, 1'b0, r0);
    smpa_master_model_i.xfer(a[15:8], 1'b0, r0);
    smpa_master_model_i.xfer(a[7:0], 1'b0, r0);
    smpa_master_model_i.xfer(d0, pz, r0);
    smpa_master_model_i.xfer(d1, 1'b0, r1);
    smpa_master_model_i.frame_end();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s[1], 1'b0)
    `SMPA_CHK(sdo_oe_n, 1'b1)
  endtask
  task automatic t_latch();
    cmd(ENABLE_WRITES_CMD);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s[1], 1'b1)
    cmd(DISABLE_WRITES_CMD);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s[1], 1'b0)
  endtask
  // All-ones write: fixed zeros stay, latch not writable and drops after
  task automatic t_status();
    cmd(ENABLE_WRITES_CMD);
    st_op(STATUS_WRITE_CMD, 8'hff);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s, 8'h8c)
    st_op(STATUS_WRITE_CMD, 8'h00);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s, 8'h8c)
    `SMPA_CHK(protection_status, 8'h8c)
  endtask
  task automatic t_pin();
    protect_n = 1'b0;
    cmd(ENABLE_WRITES_CMD);
    st_op(STATUS_WRITE_CMD, 8'h00);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s, 8'h8c)
    protect_n = 1'b1;
    cmd(ENABLE_WRITES_CMD);
    st_op(STATUS_WRITE_CMD, 8'h80);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s, 8'h80)
  endtask
  // Top address bits ignored, wrap at the end, pause mid-byte
  task automatic t_burst();
    protect_n = 1'b0;
    cmd(ENABLE_WRITES_CMD);
    mem(MEM_WRITE_CMD, 16'hffff, 8'ha5, 8'h3c, 1'b1);
    protect_n = 1'b1;
    mem(MEM_READ_CMD, 16'h1fff, 8'h5a, 8'hc3, 1'b0);
    `SMPA_CHK(r0, 8'ha5)
    `SMPA_CHK(r1, 8'h3c)
    `SMPA_CHK(sdo_oe_n, 1'b1)
  endtask
  task automatic t_no_latch();
    mem(MEM_WRITE_CMD, 16'h0000, 8'h11, 8'h22, 1'b0);
    `SMPA_CHK(smpa_master_model_i.drove, 1'b0)
    mem(MEM_READ_CMD, 16'h0000, 8'h00, 8'h00, 1'b0);
    `SMPA_CHK(r0, 8'h3c)
  endtask
  // Upper quarter guarded: burst stops at 1FFFh, no wrap into 0000h
  task automatic t_guard();
    cmd(ENABLE_WRITES_CMD);
    st_op(STATUS_WRITE_CMD, 8'h04);
    cmd(ENABLE_WRITES_CMD);
    mem(MEM_WRITE_CMD, 16'h1fff, 8'h77, 8'h88, 1'b0);
    mem(MEM_READ_CMD, 16'h1fff, 8'h00, 8'h00, 1'b0);
    `SMPA_CHK(r0, 8'ha5)
    `SMPA_CHK(r1, 8'h3c)
  endtask
  // Mid-run reset: latch drops, guard bits survive
  task automatic t_nv();
    cmd(ENABLE_WRITES_CMD);
    rst = 1'b1;
    smpa_master_model_i.tick(2);
    rst = 1'b0;
    smpa_master_model_i.tick(3);
    st_op(STATUS_READ_CMD, 8'h00);
    `SMPA_CHK(s, 8'h04)
  endtask
  task automatic t_bad_op();
    mem(8'hff, 16'h0000, 8'h00, 8'h00, 1'b0);
    `SMPA_CHK(smpa_master_model_i.drove, 1'b0)
  endtask
  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    protect_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    smpa_master_model_i.tick(3);
    t_reset();
    t_latch();
    t_status();
    t_pin();
    t_burst();
    t_no_latch();
    t_guard();
    t_nv();
    t_bad_op();
    wrap_up();
  end
  // Watchdog, well beyond the roughly 5k cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
endmodule
